// ---- tofsp_pkg.sv ----
// tofsp_pkg: constants shared by the sensor spi register port
// assumes a 40 MHz system clock; nothing else

package tofsp_pkg;
    localparam int          ADDR_BITS      = 8;
    localparam int          BYTE_BITS      = 8;
    localparam int          REG_COUNT      = 16;
    localparam int          RESULT_BASE    = 8;
    localparam logic [7:0]  TRIGGER_ADDR   = 8'h00;
    localparam logic [7:0]  CONFIG_ADDR    = 8'h01;
    localparam logic [7:0]  STATUS_ADDR    = 8'h02;
    localparam logic [7:0]  REG_RESET      = 8'h00;
    localparam int          CLOCK_MHZ      = 40;
    localparam int          FRAME_TIME_US  = 100;
    localparam int          FRAME_CYCLES   = FRAME_TIME_US * CLOCK_MHZ;
    localparam logic [2:0]  BIT_COUNT_LAST = 3'h7;

    typedef enum logic [1:0] {
        TOFSP_IDLE    = 2'b00,
        TOFSP_MEASURE = 2'b01,
        TOFSP_DONE    = 2'b11
    } tofsp_state_t;
endpackage

// ---- tofsp_shifter.sv ----
// tofsp_shifter: spi mode 3 byte engine, sampled pins oversampled at i_clock
// assumes sclk, cs and mosi already pass a two-flop synchroniser

`timescale 1ns/10ps
`default_nettype none

module tofsp_shifter (
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic       i_enable,
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_byte,
    output logic            o_tx_load,
    output logic            o_miso,
    output logic            o_first
);
    logic       sclk_prev;
    logic [2:0] bit_count;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic       first_byte;
    logic       rise;
    logic       fall;

    assign rise = i_sclk & ~sclk_prev;
    assign fall = ~i_sclk & sclk_prev;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sclk_prev <= 1'b1;
        end else if (i_enable) begin
            sclk_prev <= i_sclk;
        end
    end

    // sample on the rising edge, msb first, whole bytes only
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bit_count  <= 3'h0;
            rx_shift   <= 8'h00;
            o_rx_valid <= 1'b0;
            o_rx_byte  <= 8'h00;
            first_byte <= 1'b1;
            o_first    <= 1'b1;
        end else if (i_enable) begin
            o_rx_valid <= 1'b0;
            if (i_cs_n) begin
                // a partial byte is dropped when select is released
                bit_count  <= 3'h0;
                first_byte <= 1'b1;
            end else if (rise) begin
                rx_shift  <= {rx_shift[6:0], i_mosi};
                bit_count <= bit_count + 3'h1;
                if (bit_count == tofsp_pkg::BIT_COUNT_LAST) begin
                    o_rx_valid <= 1'b1;
                    o_rx_byte  <= {rx_shift[6:0], i_mosi};
                    o_first    <= first_byte;
                    first_byte <= 1'b0;
                end
            end
        end
    end

    // drive on the falling edge; the byte is loaded at the first fall of each byte
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tx_shift  <= 8'h00;
            o_miso    <= 1'b1;
            o_tx_load <= 1'b0;
        end else if (i_enable) begin
            o_tx_load <= 1'b0;
            if (i_cs_n) begin
                o_miso <= 1'b1;
            end else if (fall) begin
                if (bit_count == 3'h0) begin
                    o_miso    <= i_tx_byte[7];
                    tx_shift  <= {i_tx_byte[6:0], 1'b0};
                    o_tx_load <= 1'b1;
                end else begin
                    o_miso   <= tx_shift[7];
                    tx_shift <= {tx_shift[6:0], 1'b0};
                end
            end
        end
    end
endmodule // tofsp_shifter

`default_nettype wire

// ---- tofsp_port.sv ----
// tofsp_port: spi register port and one-shot measurement sequencer
// assumes sclk phases of at least five i_clock cycles and cs low per transfer
//
// Overview of operation
// - serial clock idles high between transfers, spi mode 3.
// - data changes on falling clock edge, sampled on rising edge.
// - transfer is one address byte then whole data bytes.
// - bits shift most significant first, multi-byte values big endian.
// - device runs the measurement alone, host then reads results.
// - device raises measurement done interrupt when results are ready.
// - one frame per trigger; activity stops on chip select or frame end.

`timescale 1ns/10ps
`default_nettype none

module tofsp_port #(
    parameter int FRAME_CYCLES = tofsp_pkg::FRAME_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_enable,
    input  wire logic i_sclk,
    input  wire logic i_cs_n,
    input  wire logic i_mosi,
    output logic      o_miso,
    output logic      o_miso_oe,
    output logic      o_measurement_done_irq,
    output logic      o_busy
);
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic       cs_prev;
    logic       cs_fall;
    logic       rx_valid;
    logic [7:0] rx_byte;
    logic       rx_first;
    logic       miso_raw;
    logic [7:0] regs [tofsp_pkg::REG_COUNT];
    logic [7:0] addr;
    logic       write_mode;
    logic [7:0] tx_byte;
    logic       trigger;
    logic [31:0] frame_count;
    tofsp_pkg::tofsp_state_t state;
    tofsp_pkg::tofsp_state_t next_state;

    // two flops on every pin; sclk idles high, cs idles released
    // the edge search needs each sclk phase for only a clock, but miso reaches the pin about four clocks after a fall, which
    // caps sclk far below the pin's own limit at this clock rate
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sclk_sync <= 2'h3;
            cs_sync   <= 2'h3;
            mosi_sync <= 2'h0;
        end else if (i_enable) begin
            sclk_sync <= {sclk_sync[0], i_sclk};
            cs_sync   <= {cs_sync[0], i_cs_n};
            mosi_sync <= {mosi_sync[0], i_mosi};
        end
    end

    // a new select during a frame aborts it; the select that carried the
    // trigger was already low when the frame began, so only a fall counts
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cs_prev <= 1'b1;
        end else if (i_enable) begin
            cs_prev <= cs_sync[1];
        end
    end

    assign cs_fall = cs_prev && !cs_sync[1];

    tofsp_shifter u_shifter (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_enable  (i_enable),
        .i_sclk    (sclk_sync[1]),
        .i_cs_n    (cs_sync[1]),
        .i_mosi    (mosi_sync[1]),
        .i_tx_byte (tx_byte),
        .o_rx_valid(rx_valid),
        .o_rx_byte (rx_byte),
        .o_tx_load (),
        .o_miso    (miso_raw),
        .o_first   (rx_first)
    );

    // address byte: bit 7 set means write, low bits pick the register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            addr       <= 8'h00;
            write_mode <= 1'b0;
        end else if (i_enable) begin
            if (rx_valid && rx_first) begin
                addr       <= {1'b0, rx_byte[6:0]};
                write_mode <= rx_byte[7];
            end else if (rx_valid) begin
                // step after every data byte, read or write, so the next byte
                // loaded or written is the following register: big endian
                addr <= addr + 8'h01;
            end
        end
    end

    // a completed data byte of a write; the address byte never counts
    function automatic logic data_write(
        input logic valid,
        input logic first,
        input logic wr
    );
        return valid && !first && wr;
    endfunction

    // last counted cycle of a measurement frame
    function automatic logic frame_last(input logic [31:0] count);
        return count == 32'(FRAME_CYCLES - 1);
    endfunction

    assign tx_byte = regs[addr[3:0]];

    // register writes; results are filled by the sequencer, status is read only
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int i = 0; i < tofsp_pkg::REG_COUNT; i++) begin
                regs[i] <= tofsp_pkg::REG_RESET;
            end
        end else if (i_enable) begin
            if (data_write(rx_valid, rx_first, write_mode)
                && addr < 8'(tofsp_pkg::RESULT_BASE)
                && addr != tofsp_pkg::STATUS_ADDR) begin
                regs[addr[3:0]] <= rx_byte;
            end
            regs[tofsp_pkg::STATUS_ADDR[3:0]] <= {6'h00, o_measurement_done_irq, o_busy};
            if (state == tofsp_pkg::TOFSP_MEASURE && frame_last(frame_count)) begin
                // result bytes are the config register xor their own register index
                for (int i = tofsp_pkg::RESULT_BASE; i < tofsp_pkg::REG_COUNT; i++) begin
                    regs[i] <= regs[tofsp_pkg::CONFIG_ADDR[3:0]] ^ 8'(i);
                end
            end
        end
    end

    // a write of 1 to the trigger address starts exactly one frame
    assign trigger = data_write(rx_valid, rx_first, write_mode)
                     && addr == tofsp_pkg::TRIGGER_ADDR && rx_byte[0];

    always_comb begin
        next_state = state;
        unique case (state)
            tofsp_pkg::TOFSP_IDLE: begin
                if (trigger) begin
                    next_state = tofsp_pkg::TOFSP_MEASURE;
                end
            end
            tofsp_pkg::TOFSP_MEASURE: begin
                // a fresh select aborts; the triggering one fell before the frame
                if (cs_fall) begin
                    next_state = tofsp_pkg::TOFSP_IDLE;
                end else if (frame_last(frame_count)) begin
                    next_state = tofsp_pkg::TOFSP_DONE;
                end
            end
            tofsp_pkg::TOFSP_DONE: begin
                if (trigger) begin
                    next_state = tofsp_pkg::TOFSP_MEASURE;
                end
            end
            default: next_state = tofsp_pkg::TOFSP_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= tofsp_pkg::TOFSP_IDLE;
        end else if (i_enable) begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            frame_count <= 32'h0;
        end else if (i_enable) begin
            if (state == tofsp_pkg::TOFSP_MEASURE) begin
                frame_count <= frame_count + 32'h1;
            end else begin
                frame_count <= 32'h0;
            end
        end
    end

    // done line stays high until the next frame is triggered
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_measurement_done_irq <= 1'b0;
            o_busy                 <= 1'b0;
        end else if (i_enable) begin
            o_measurement_done_irq <= (next_state == tofsp_pkg::TOFSP_DONE);
            o_busy                 <= (next_state == tofsp_pkg::TOFSP_MEASURE);
        end
    end

    // miso is retimed once more so the pin comes from a flop; the host sees
    // each bit about four clocks after its falling sclk edge
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_miso    <= 1'b1;
            o_miso_oe <= 1'b0;
        end else if (i_enable) begin
            o_miso    <= miso_raw;
            o_miso_oe <= !cs_sync[1];
        end
    end
endmodule // tofsp_port

`default_nettype wire

// ---- tofsp_port_properties.sv ----
// tofsp_port_properties: pin level checks on the sensor spi port
// assumes sclk phases of at least 5 clocks and a bound to tofsp_port
`timescale 1ns/10ps
`default_nettype none
module tofsp_port_properties #(
    parameter int FRAME_CYCLES = tofsp_pkg::FRAME_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_enable,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic o_measurement_done_irq,
    input wire logic o_busy
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic        busy_q;
    logic [15:0] run_cnt;
    // counts enabled busy cycles so the frame length can be judged at irq rise
    always_ff @(posedge i_clock) begin
        busy_q <= o_busy;
        if (i_rst) run_cnt <= 16'h0000;
        else if (o_busy && !busy_q) run_cnt <= 16'h0001;
        else if (o_busy && i_enable) run_cnt <= run_cnt + 16'h0001;
    end
    a_oe_off_idle: assert property ((i_cs_n && i_enable) [*5] |=> !o_miso_oe && o_miso)
        else $error("miso driven while deselected");
    a_oe_on_sel: assert property ((!i_cs_n && i_enable) [*5] |=> o_miso_oe)
        else $error("miso not driven while selected");
    a_miso_on_fall: assert property ($changed(o_miso) && !i_cs_n && !$past(i_cs_n, 10)
        |-> !$past(i_sclk, 6) || !$past(i_sclk, 5) || !$past(i_sclk, 4))
        else $error("miso moved during a high sclk phase");
    a_busy_irq_excl: assert property (!(o_busy && o_measurement_done_irq))
        else $error("busy and done both high");
    a_irq_after_frame: assert property ($rose(o_measurement_done_irq) |-> $past(o_busy)
        && int'(run_cnt) >= FRAME_CYCLES - 2 && int'(run_cnt) <= FRAME_CYCLES + 2)
        else $error("done raised without a full frame");
    a_irq_holds: assert property (o_measurement_done_irq && i_cs_n && $past(i_cs_n, 6)
        |=> o_measurement_done_irq)
        else $error("done dropped without a trigger");
    a_busy_by_xfer: assert property ($rose(o_busy) |-> !$past(i_cs_n, 3))
        else $error("frame started outside a transfer");
    a_abort_stop: assert property ($fell(i_cs_n) && o_busy |-> ##[1:8] !o_busy)
        else $error("frame kept running after select");
    a_enable_freeze: assert property (!i_enable |=> $stable(o_busy)
        && $stable(o_measurement_done_irq))
        else $error("state moved while disabled");
    c_done: cover property ($rose(o_measurement_done_irq));
    c_abort: cover property ($fell(i_cs_n) && o_busy);
    c_freeze: cover property (!i_enable && o_busy);
endmodule // tofsp_port_properties
bind tofsp_port tofsp_port_properties #(.FRAME_CYCLES(FRAME_CYCLES)) tofsp_port_properties_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_enable(i_enable), .i_sclk(i_sclk),
    .i_cs_n(i_cs_n), .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
    .o_measurement_done_irq(o_measurement_done_irq), .o_busy(o_busy));
`default_nettype wire

// ---- tofsp_host.sv ----
// tofsp_host: behavioural spi mode 3 master standing in for the host
// assumes the bench calls xfer one at a time
`timescale 1ns/10ps
`default_nettype none
module tofsp_host (
    input  wire logic i_clock,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    int half = 8;
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #2;
    endtask
    task automatic run_bits(input logic [23:0] sh, input int bits, output logic [15:0] q);
        q = 16'h0000;
        // select stays released for a whole sclk phase between transfers
        tick(half);
        o_cs_n = 1'b0;
        tick(half);
        for (int i = bits - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_mosi = sh[i];
            tick(half);
            o_sclk = 1'b1;
            q = {q[14:0], i_miso};
            tick(half);
        end
        o_cs_n = 1'b1;
        // released line must not keep looking like data
        o_mosi = ~o_mosi;
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        run_bits({8'h00, a, d}, 16, w);
        q = w[7:0];
    endtask
    // address then two data bytes, high byte first
    task automatic read2(input logic [7:0] a, output logic [15:0] q);
        run_bits({a, 16'h0000}, 24, q);
    endtask
endmodule // tofsp_host
`default_nettype wire

// ---- tb.sv ----
// tb: self-checking bench for the sensor spi port
// assumes tofsp_host as the spi master and a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int FRAME = 400;
    logic       i_clock = 1'b0;
    logic       rst     = 1'b1;
    logic       en      = 1'b1;
    wire        sclk, cs_n, mosi, miso, oe, irq, busy;
    int         err_count    = 0;
    int         total_checks = 0;
    logic [7:0] q;
    logic [15:0] w;
    always #12.5 i_clock = ~i_clock;
    tofsp_host tofsp_host_i (.i_clock(i_clock), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_mosi(mosi), .i_miso(miso));
    tofsp_port #(.FRAME_CYCLES(FRAME)) tofsp_port_i (.i_clock(i_clock), .i_rst(rst),
        .i_enable(en), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe(oe), .o_measurement_done_irq(irq), .o_busy(busy));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_reset();
        check("flags", {6'h00, irq, busy}, 8'h00);
        check("pins", {6'h00, oe, miso}, 8'h01);
        $display("done reset");
    endtask
    task automatic t_config();
        tofsp_host_i.xfer(8'h81, 8'h5a, q);
        tofsp_host_i.half = 12;
        tofsp_host_i.xfer(8'h01, 8'h00, q);
        check("config", q, 8'h5a);
        tofsp_host_i.half = 8;
        tofsp_host_i.xfer(8'h82, 8'hff, q);
        tofsp_host_i.xfer(8'h02, 8'h00, q);
        check("status", q, 8'h00);
        tofsp_host_i.xfer(8'h88, 8'hff, q);
        tofsp_host_i.xfer(8'h08, 8'h00, q);
        check("result ro", q, 8'h00);
        tofsp_host_i.xfer(8'h11, 8'h00, q);
        check("alias", q, 8'h5a);
        $display("done config");
    endtask
    task automatic t_frame();
        tofsp_host_i.xfer(8'h80, 8'h01, q);
        check("running", {6'h00, irq, busy}, 8'h01);
        en = 1'b0;
        repeat (30) @(posedge i_clock);
        check("frozen", {6'h00, irq, busy}, 8'h01);
        #2 en = 1'b1;
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge i_clock);
        #2 check("finished", {6'h00, irq, busy}, 8'h02);
        repeat (3 * FRAME) @(posedge i_clock);
        check("one frame", {6'h00, irq, busy}, 8'h02);
        tofsp_host_i.xfer(8'h02, 8'h00, q);
        check("status", q, 8'h02);
        tofsp_host_i.read2(8'h08, w);
        check("result hi", w[15:8], 8'h52);
        check("result lo", w[7:0], 8'h53);
        $display("done frame");
    endtask
    task automatic t_abort();
        tofsp_host_i.xfer(8'h80, 8'h01, q);
        check("retrigger", {6'h00, irq, busy}, 8'h01);
        tofsp_host_i.xfer(8'h01, 8'h00, q);
        repeat (2 * FRAME) @(posedge i_clock);
        check("aborted", {6'h00, irq, busy}, 8'h00);
        $display("done abort");
    endtask
    // whole run needs well under 10000 cycles; twice that means a hang
    initial begin
        repeat (20000) @(posedge i_clock);
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge i_clock);
        #2 rst = 1'b0;
        t_reset();
        t_config();
        t_frame();
        t_abort();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
